// file: common/lra_pkg.sv
// constants for the display RAM command interpreter
package lra_pkg;
    // command codes
    localparam logic [7:0] CMD_WR_DATA  = 8'h1D;
    localparam logic [7:0] CMD_RD_DATA  = 8'h1C;
    localparam logic [7:0] CMD_DIR_COL  = 8'h84;
    localparam logic [7:0] CMD_DIR_PAGE = 8'h85;
    localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
    localparam logic [7:0] CMD_SEG_REV  = 8'hA1;
    localparam logic [7:0] CMD_INV_SET  = 8'h36;
    // address space
    localparam logic [7:0] COL_LAST     = 8'hB3;
    localparam logic [5:0] PAGE_LAST    = 6'h20;
    localparam int         COL_COUNT    = 180;
    localparam int         RAM_WORDS    = 5940;
    localparam int         RAM_AW       = 13;
    // inversion line count
    localparam logic [5:0] INV_CODE_RST = 6'h00;
    localparam logic [7:0] INV_LINE_RST = 8'h04;
    // fifo shape
    localparam int         FIFO_WIDTH   = 9;
    localparam int         FIFO_DEPTH   = 16;
    // wishbone map, byte addresses
    localparam logic [3:0] OFS_ADDR     = 4'h0;
    localparam logic [3:0] OFS_STAT     = 4'h4;
    localparam int         ADDR_COL_LSB = 0;
    localparam int         ADDR_PG_LSB  = 8;
    localparam int         ST_DIR_BIT   = 0;
    localparam int         ST_SEG_BIT   = 1;
    localparam int         ST_RD_BIT    = 2;
    localparam int         ST_WR_BIT    = 3;
    localparam int         ST_EMPTY_BIT = 4;
    localparam int         ST_LINE_LSB  = 8;
    localparam int         ST_CODE_LSB  = 16;
    // decoder modes, gray along idle-write-read-param
    typedef enum logic [1:0] {
        MODE_IDLE  = 2'b00,
        MODE_WRITE = 2'b01,
        MODE_READ  = 2'b11,
        MODE_PARAM = 2'b10
    } lra_mode_e;
endpackage

// file: hw/lra_top.sv
// display RAM access command interpreter with its byte fifo
`timescale 1ns/10ps
`default_nettype none

// byte fifo between host pins and decoder
module lra_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW:0]      wrPtr_ff;
    logic [PW:0]      rdPtr_ff;
    logic             full;
    logic             empty;

    // full when pointers differ only in wrap bit
    assign full     = (wrPtr_ff[PW] != rdPtr_ff[PW]) &&
                      (wrPtr_ff[PW-1:0] == rdPtr_ff[PW-1:0]);
    assign empty    = (wrPtr_ff == rdPtr_ff);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr_ff[PW-1:0]];

    // storage
    always_ff @(posedge clk)
    begin
        if (inValid && !full)
            mem[wrPtr_ff[PW-1:0]] <= inData;
    end

    // pointers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end
        else
        begin
            if (inValid && !full)
                wrPtr_ff <= wrPtr_ff + 1'b1;
            if (outReady && !empty)
                rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end
endmodule

// Contract
// - write-data command stores following bytes
// - each access advances column or page
// - read-data command returns byte per read
// - serial mode has no read path
// - 0x84 column, 0x85 page increment
// - reset selects column increment
// - 0xA0 normal, 0xA1 mirrored segments
// - mirroring never changes column increment
// - reset selects normal segment mapping
// - 0x36 parameter loads inversion line count
// - line count is (value+1) times four
// - reset sets four inversion lines
module lra_top (
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [3:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic [31:0]      wbDatO,
    output logic             wbAck,
    // host pins
    input  wire logic        cmdDataSelect,
    input  wire logic        hostWrN,
    input  wire logic        hostRdN,
    input  wire logic [7:0]  hostDataIn,
    output logic [7:0]       hostDataOut,
    output logic             hostDataOe,
    output logic             hostBusy,
    input  wire logic        serialSel,
    input  wire logic        serialClk,
    input  wire logic        serialData,
    // display settings
    output logic             segMirror,
    output logic             dirPage,
    output logic [7:0]       invLines
);
    // pin synchronisers, stage1 feeds stage2 only
    logic [13:0] pinS1_ff;
    logic [13:0] pinS2_ff;
    logic        wrDly_ff;
    logic        rdDly_ff;
    logic        sckDly_ff;
    logic        sCds;
    logic        sWrN;
    logic        sRdN;
    logic [7:0]  sData;
    logic        sSer;
    logic        sSck;
    logic        sSdi;
    // serial shifter
    logic [6:0]  shift_ff;
    logic [2:0]  bitCnt_ff;
    // fifo ports
    logic [8:0]  pushData;
    logic        pushValid;
    logic        pushReady;
    logic [8:0]  popData;
    logic        popValid;
    logic        popReady;
    // state
    lra_pkg::lra_mode_e mode_ff;
    logic [7:0]  col_ff;
    logic [5:0]  page_ff;
    logic [5:0]  invCode_ff;
    logic [7:0]  readLatch_ff;
    logic        rdActive_ff;
    logic        wbAck_ff;
    logic [31:0] wbDatO_ff;
    logic [7:0]  hostDataOut_ff;
    logic        hostDataOe_ff;
    logic        hostBusy_ff;
    logic        segMirror_ff;
    logic        dirPage_ff;
    logic [7:0]  invLines_ff;
    logic [7:0]  ram [0:lra_pkg::RAM_WORDS-1];
    logic [lra_pkg::RAM_AW-1:0] ramIdx;
    logic        popCmd;
    logic        popDat;
    logic        ramWrite;
    logic        readDone;
    logic        readOk;
    logic        advance;
    logic        busWr;
    logic        busAddrWr;

    // two-flop synchronisers for all host pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // strobes idle high, parallel mode, sclk parked low
            pinS1_ff <= 14'h3000;
            pinS2_ff <= 14'h3000;
        end
        else
        begin
            pinS1_ff <= {hostRdN, hostWrN, cmdDataSelect, serialSel,
                         serialClk, serialData, hostDataIn};
            pinS2_ff <= pinS1_ff;
        end
    end
    assign {sRdN, sWrN, sCds, sSer, sSck, sSdi} = pinS2_ff[13:8];
    assign sData = pinS2_ff[7:0];

    // edge detectors read stage two only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrDly_ff  <= 1'b1;
            rdDly_ff  <= 1'b1;
            sckDly_ff <= 1'b0;
        end
        else
        begin
            wrDly_ff  <= sWrN;
            rdDly_ff  <= sRdN;
            sckDly_ff <= sSck;
        end
    end

    // serial bytes shift in msb first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shift_ff  <= '0;
            bitCnt_ff <= '0;
        end
        else if (!sSer)
            bitCnt_ff <= '0;
        else if (sSck && !sckDly_ff)
        begin
            shift_ff  <= {shift_ff[5:0], sSdi};
            bitCnt_ff <= bitCnt_ff + 3'd1;
        end
    end

    // byte with its select bit goes to the fifo
    always_comb
    begin
        pushValid = 1'b0;
        pushData  = {sCds, sData};
        if (sSer)
        begin
            pushValid = sSck && !sckDly_ff && (bitCnt_ff == 3'd7);
            pushData  = {sCds, shift_ff, sSdi};
        end
        else
            pushValid = sWrN && !wrDly_ff;
    end

    lra_fifo #(
        .WIDTH (lra_pkg::FIFO_WIDTH),
        .DEPTH (lra_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inData   (pushData),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (popData),
        .outValid (popValid),
        .outReady (popReady)
    );

    // decoder stalls while a host read is open
    assign popReady = !rdActive_ff;
    assign popCmd   = popValid && popReady && !popData[8];
    assign popDat   = popValid && popReady && popData[8];
    assign ramWrite = popDat && (mode_ff == lra_pkg::MODE_WRITE);
    assign readOk   = (mode_ff == lra_pkg::MODE_READ) && !popValid
                      && !sSer;
    assign readDone = rdActive_ff && sRdN && !rdDly_ff;
    assign advance  = ramWrite || readDone;
    assign ramIdx   = lra_pkg::RAM_AW'(page_ff * lra_pkg::COL_COUNT)
                      + lra_pkg::RAM_AW'(col_ff);

    // command decode and mode tracking
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_ff      <= lra_pkg::MODE_IDLE;
            dirPage_ff   <= 1'b0;
            segMirror_ff <= 1'b0;
            invCode_ff   <= lra_pkg::INV_CODE_RST;
            invLines_ff  <= lra_pkg::INV_LINE_RST;
        end
        else if (popCmd)
        begin
            case (popData[7:0])
                lra_pkg::CMD_WR_DATA:  mode_ff <= lra_pkg::MODE_WRITE;
                lra_pkg::CMD_RD_DATA:  mode_ff <= lra_pkg::MODE_READ;
                lra_pkg::CMD_INV_SET:  mode_ff <= lra_pkg::MODE_PARAM;
                default:               mode_ff <= lra_pkg::MODE_IDLE;
            endcase
            if (popData[7:1] == lra_pkg::CMD_DIR_COL[7:1])
                dirPage_ff <= popData[0];
            if (popData[7:1] == lra_pkg::CMD_SEG_NORM[7:1])
                segMirror_ff <= popData[0];
        end
        else if (popDat && (mode_ff == lra_pkg::MODE_PARAM))
        begin
            invCode_ff  <= popData[5:0];
            invLines_ff <= {popData[5:0] + 6'd1, 2'b00};
            mode_ff     <= lra_pkg::MODE_IDLE;
        end
        // write and read modes persist
    end

    // display RAM write
    always_ff @(posedge clk)
    begin
        if (ramWrite)
            ram[ramIdx] <= popData[7:0];
    end

    // address counters, bus write wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            col_ff  <= '0;
            page_ff <= '0;
        end
        else if (busAddrWr)
        begin
            col_ff  <= wbDatI[lra_pkg::ADDR_COL_LSB +: 8];
            page_ff <= wbDatI[lra_pkg::ADDR_PG_LSB +: 6];
        end
        else if (advance)
        begin
            // mirroring plays no part here
            if (!dirPage_ff)
                col_ff <= (col_ff == lra_pkg::COL_LAST) ? 8'h00
                          : col_ff + 8'd1;
            else
                page_ff <= (page_ff == lra_pkg::PAGE_LAST) ? 6'h00
                           : page_ff + 6'd1;
        end
    end

    // read latch: answer then refill, so first read is dummy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdActive_ff    <= 1'b0;
            readLatch_ff   <= '0;
            hostDataOut_ff <= '0;
            hostDataOe_ff  <= 1'b0;
        end
        else
        begin
            if (!rdActive_ff && readOk && !sRdN && rdDly_ff)
            begin
                rdActive_ff    <= 1'b1;
                hostDataOut_ff <= readLatch_ff;
                hostDataOe_ff  <= 1'b1;
            end
            else if (readDone)
            begin
                rdActive_ff   <= 1'b0;
                hostDataOe_ff <= 1'b0;
                readLatch_ff  <= ram[ramIdx];
            end
        end
    end

    // wishbone slave, one wait state
    assign busWr     = wbCyc && wbStb && wbWe && !wbAck_ff;
    assign busAddrWr = busWr && (wbAdr == lra_pkg::OFS_ADDR) && wbSel[0];
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wbAck_ff  <= 1'b0;
            wbDatO_ff <= '0;
        end
        else
        begin
            wbAck_ff  <= wbCyc && wbStb && !wbAck_ff;
            wbDatO_ff <= '0;
            if (wbCyc && wbStb && !wbAck_ff && !wbWe)
            begin
                case (wbAdr)
                    lra_pkg::OFS_ADDR:
                    begin
                        wbDatO_ff[lra_pkg::ADDR_COL_LSB +: 8] <= col_ff;
                        wbDatO_ff[lra_pkg::ADDR_PG_LSB +: 6]  <= page_ff;
                    end
                    lra_pkg::OFS_STAT:
                    begin
                        wbDatO_ff[lra_pkg::ST_DIR_BIT]   <= dirPage_ff;
                        wbDatO_ff[lra_pkg::ST_SEG_BIT]   <= segMirror_ff;
                        wbDatO_ff[lra_pkg::ST_RD_BIT]    <=
                            (mode_ff == lra_pkg::MODE_READ);
                        wbDatO_ff[lra_pkg::ST_WR_BIT]    <=
                            (mode_ff == lra_pkg::MODE_WRITE);
                        wbDatO_ff[lra_pkg::ST_EMPTY_BIT] <= !popValid;
                        wbDatO_ff[lra_pkg::ST_LINE_LSB +: 8] <= invLines_ff;
                        wbDatO_ff[lra_pkg::ST_CODE_LSB +: 6] <= invCode_ff;
                    end
                    default: wbDatO_ff <= '0;
                endcase
            end
        end
    end

    // busy tells the host the fifo is full
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hostBusy_ff <= 1'b0;
        else
            hostBusy_ff <= !pushReady;
    end

    assign wbDatO      = wbDatO_ff;
    assign wbAck       = wbAck_ff;
    assign hostDataOut = hostDataOut_ff;
    assign hostDataOe  = hostDataOe_ff;
    assign hostBusy    = hostBusy_ff;
    assign segMirror   = segMirror_ff;
    assign dirPage     = dirPage_ff;
    assign invLines    = invLines_ff;
endmodule

`default_nettype wire

// file: testbench/lra_top_assertions.sv
// concurrent checks on the command interpreter ports
`timescale 1ns/10ps
`default_nettype none
module lra_top_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic [3:0]  wbAdr,
    input wire logic [31:0] wbDatO,
    input wire logic        wbAck,
    input wire logic        hostRdN,
    input wire logic        hostDataOe,
    input wire logic        serialSel,
    input wire logic        segMirror,
    input wire logic        dirPage,
    input wire logic [7:0]  invLines
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // bus request waiting, and a read being answered
    sequence s_req;
        wbCyc && wbStb && !wbAck;
    endsequence
    sequence s_stat_rd;
        wbAck && !wbWe && wbAdr == 4'h4;
    endsequence
    // defaults right after reset release
    a_rst_dir: assert property ($fell(rst) |-> !dirPage)
        else $error("direction not column after reset");
    a_rst_mirror: assert property ($fell(rst) |-> !segMirror)
        else $error("mapping not normal after reset");
    a_rst_lines: assert property (
        $fell(rst) |-> invLines == 8'h04)
        else $error("line count not four after reset");
    // line count in steps of four, 4 to 132
    a_lines_range: assert property (
        invLines[1:0] == 2'h0 && invLines >= 8'h04 && invLines <= 8'h84)
        else $error("line count out of range");
    // bus answers after one wait state, for one cycle
    a_ack_timely: assert property (s_req |=> wbAck)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    // status fields agree with outputs and the count formula
    a_stat_fields: assert property (s_stat_rd |->
        wbDatO[15:8] == ({2'h0, wbDatO[21:16]} + 8'h01) * 8'h04
        && wbDatO[0] == dirPage && wbDatO[1] == segMirror)
        else $error("status fields wrong");
    // read drive only for a parallel read strobe, released soon after
    a_serial_noread: assert property ($rose(hostDataOe) |->
        !serialSel && !$past(serialSel, 4)) else $error("drive in serial mode");
    a_oe_cause: assert property ($rose(hostDataOe) |-> !hostRdN
        && !$past(hostRdN, 2)) else $error("drive without read strobe");
    a_oe_release: assert property (
        $rose(hostRdN) |-> ##[1:8] !hostDataOe)
        else $error("drive held after read strobe");
endmodule
`default_nettype wire

// file: testbench/lra_host.sv
// host processor model on the parallel and serial pins
`timescale 1ns/10ps
`default_nettype none
module lra_host (
    input  wire logic       clk,
    input  wire logic [7:0] hostDataOut,
    input  wire logic       hostDataOe,
    output logic            cmdDataSelect,
    output logic            hostWrN,
    output logic            hostRdN,
    output logic [7:0]      hostDataIn,
    output logic            serialSel,
    output logic            serialClk,
    output logic            serialData
);
    // idle levels, serial clock parked low
    initial
    begin
        cmdDataSelect = 1'b0;
        hostWrN = 1'b1;
        hostRdN = 1'b1;
        hostDataIn = 8'h00;
        serialSel = 1'b0;
        serialClk = 1'b0;
        serialData = 1'b0;
    end
    // one byte, select and data held around the strobe
    task automatic wr(input logic sel, input logic [7:0] b);
        @(posedge clk);
        cmdDataSelect <= sel;
        hostDataIn <= b;
        hostWrN <= 1'b0;
        repeat (4) @(posedge clk);
        hostWrN <= 1'b1;
        repeat (4) @(posedge clk);
        hostDataIn <= ~b; // released bus shows inverse
        repeat (6) @(posedge clk);
    endtask
    // one read strobe, held until drive appears or gives up
    task automatic rd(output logic [7:0] q, output logic oe);
        int n;
        n = 0;
        @(posedge clk);
        hostRdN <= 1'b0;
        do @(posedge clk); while (hostDataOe !== 1'b1 && ++n < 8);
        q = hostDataOut;
        oe = hostDataOe;
        hostRdN <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // serial byte, msb first, select taken with last bit
    task automatic ser(input logic sel, input logic [7:0] b);
        @(posedge clk);
        serialSel <= 1'b1;
        cmdDataSelect <= sel;
        repeat (4) @(posedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            serialData <= b[i];
            repeat (4) @(posedge clk);
            serialClk <= 1'b1;
            repeat (4) @(posedge clk);
            serialClk <= 1'b0;
        end
        serialData <= ~b[0];
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checkCount++; \
        if ((got) !== (exp)) \
        begin \
            numErrors++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb;
    logic        clk, rst, wbCyc, wbStb, wbWe, wbAck;
    logic [3:0]  wbAdr, wbSel;
    logic [31:0] wbDatI, wbDatO;
    logic        cmdDataSelect, hostWrN, hostRdN, hostDataOe, hostBusy;
    logic [7:0]  hostDataIn, hostDataOut, invLines;
    logic        serialSel, serialClk, serialData, segMirror, dirPage;
    int          numErrors;
    int          checkCount;
    lra_top lra_top_i (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
        .wbDatI, .wbDatO, .wbAck, .cmdDataSelect, .hostWrN, .hostRdN,
        .hostDataIn, .hostDataOut, .hostDataOe, .hostBusy, .serialSel,
        .serialClk, .serialData, .segMirror, .dirPage, .invLines);
    lra_host lra_host_i (.clk, .hostDataOut, .hostDataOe, .cmdDataSelect,
        .hostWrN, .hostRdN, .hostDataIn, .serialSel, .serialClk, .serialData);
    // 25 ns clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // verdict and end of run
    task automatic complete_run();
        if (numErrors == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one classic bus cycle, waits for ack
    task automatic wbx(input logic we, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'hF;
        wbDatI <= d;
        // ends on ack; only the watchdog ends a wait that hangs
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    // direction and mapping commands, then a stray data byte
    task automatic t_modes();
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_PAGE);
        `CHK(dirPage, 1'b1)
        lra_host_i.wr(1'b0, lra_pkg::CMD_SEG_REV);
        `CHK(segMirror, 1'b1)
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_COL);
        `CHK(dirPage, 1'b0)
        lra_host_i.wr(1'b0, lra_pkg::CMD_SEG_NORM);
        `CHK(segMirror, 1'b0)
        lra_host_i.wr(1'b1, lra_pkg::CMD_DIR_PAGE);
        `CHK(dirPage, 1'b0)
        `CHK(hostBusy, 1'b0)
    endtask
    // line count codes at both ends; none above 0x20 sent
    task automatic t_inv();
        logic [7:0]  codes [4] = '{8'h00, 8'h01, 8'h1F, 8'h20};
        logic [31:0] q;
        foreach (codes[i])
        begin
            lra_host_i.wr(1'b0, lra_pkg::CMD_INV_SET);
            lra_host_i.wr(1'b1, codes[i]);
            `CHK(invLines, 8'((codes[i] + 8'h01) * 8'h04))
            wbx(1'b0, 4'h4, 32'h0000_0000, q);
            `CHK(q[21:16], codes[i][5:0])
        end
    endtask
    // second reset in mid-run, then bus map checks
    task automatic t_reset();
        logic [31:0] q;
        lra_host_i.wr(1'b0, lra_pkg::CMD_SEG_REV);
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_PAGE);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(dirPage, 1'b0)
        `CHK(segMirror, 1'b0)
        `CHK(invLines, 8'h04)
        wbx(1'b1, 4'h4, 32'hFFFF_FFFF, q);
        wbx(1'b0, 4'h4, 32'h0000_0000, q);
        `CHK(q[15:0], 16'h0410)
        wbx(1'b0, 4'h8, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
    endtask
    // column run under mirroring, page run, then both read back
    task automatic t_ram();
        logic [7:0]  pat [3] = '{8'hAA, 8'h55, 8'hC3};
        logic [31:0] q;
        logic [7:0]  d;
        logic        oe;
        wbx(1'b1, 4'h0, 32'h0000_0110, q);
        lra_host_i.wr(1'b0, lra_pkg::CMD_SEG_REV);
        lra_host_i.wr(1'b0, lra_pkg::CMD_WR_DATA);
        foreach (pat[i]) lra_host_i.wr(1'b1, pat[i]);
        wbx(1'b0, lra_pkg::OFS_STAT, 32'h0000_0000, q);
        `CHK(q[lra_pkg::ST_WR_BIT], 1'b1)
        wbx(1'b1, 4'h0, 32'h0000_0220, q);
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_PAGE);
        lra_host_i.wr(1'b0, lra_pkg::CMD_WR_DATA);
        lra_host_i.wr(1'b1, 8'h5A);
        lra_host_i.wr(1'b1, 8'hA5);
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_COL);
        wbx(1'b1, 4'h0, 32'h0000_0110, q);
        lra_host_i.wr(1'b0, lra_pkg::CMD_RD_DATA);
        wbx(1'b0, lra_pkg::OFS_STAT, 32'h0000_0000, q);
        `CHK(q[lra_pkg::ST_RD_BIT], 1'b1)
        lra_host_i.rd(d, oe);
        foreach (pat[i])
        begin
            lra_host_i.rd(d, oe);
            `CHK(d, pat[i])
        end
        lra_host_i.wr(1'b0, lra_pkg::CMD_DIR_PAGE);
        wbx(1'b1, 4'h0, 32'h0000_0220, q);
        lra_host_i.wr(1'b0, lra_pkg::CMD_RD_DATA);
        lra_host_i.rd(d, oe);
        lra_host_i.rd(d, oe);
        `CHK(d, 8'h5A)
        lra_host_i.rd(d, oe);
        `CHK(d, 8'hA5)
    endtask
    // serial writes work, serial reads are not driven
    task automatic t_serial();
        logic [7:0] d;
        logic       oe;
        lra_host_i.ser(1'b0, lra_pkg::CMD_SEG_NORM);
        `CHK(segMirror, 1'b0)
        lra_host_i.ser(1'b0, lra_pkg::CMD_RD_DATA);
        lra_host_i.rd(d, oe);
        `CHK(oe, 1'b0)
    endtask
    // main sequence
    initial
    begin
        rst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 4'h0;
        wbSel = 4'hF;
        wbDatI = 32'h0000_0000;
        numErrors = 0;
        checkCount = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_modes();
        t_inv();
        t_reset();
        t_ram();
        t_serial();
        complete_run();
    end
    // watchdog against a hang
    initial
    begin
        #(25 * 10000);
        numErrors++;
        complete_run();
    end
endmodule
bind lra_top lra_top_assertions lra_top_assertions_i (.clk, .rst, .wbCyc,
    .wbStb, .wbWe, .wbAdr, .wbDatO, .wbAck, .hostRdN, .hostDataOe,
    .serialSel, .segMirror, .dirPage, .invLines);
`default_nettype wire
